/* File: hw/afh_edge_latch.sv */
// Edge detector and pending latch for the fixed edge interrupt input
`timescale 1ns/100ps
`default_nettype none
module afh_edge_latch
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Interrupt input and acknowledge
  input  wire logic i_level,
  input  wire logic i_int_ack,
  // Latched state
  output logic      o_pending,
  output logic      o_level_now
);
  logic prev_level;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      prev_level <= 1'h0;
    else
      prev_level <= i_level;
  end

  // Set wins over clear so a new edge during acknowledge is kept
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_pending <= 1'h0;
    else if (i_level && !prev_level)
      o_pending <= 1'h1; // [RULE_06]
    else if (i_int_ack)
      o_pending <= 1'h0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_level_now <= 1'h0;
    else
      o_level_now <= i_level;
  end

  a_edge_sets_pend: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_06]
    (i_level && !prev_level) |=> o_pending)
    else $error("edge not latched");
endmodule : afh_edge_latch
`default_nettype wire

/* File: hw/afh_pkg.sv */
// Package of constants for the flush handshake and interrupt pin block
package afh_pkg;
  // Default vector index reported for a request that vanished before acknowledge
  localparam logic [2:0] AFH_SPURIOUS_LINE    = 3'h7;
  localparam logic [2:0] AFH_FIXED_EDGE_LINE  = 3'h1;
  // Pin levels after reset
  localparam logic       AFH_ACK_N_RESET      = 1'h1;
  localparam logic       AFH_TIMER_OUT_RESET  = 1'h0;
  // Flush sequencer states
  typedef enum logic [1:0] {
    afh_idle_t_s,
    afh_flush_s,
    afh_ack_s
  } afh_state_t;
endpackage : afh_pkg

/* File: hw/afh_top.sv */
// Flush handshake toward an external APIC plus timer and edge interrupt pins
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE_01 - The external APIC pulls the flush request low before sending any serial interrupt.
// RULE_02 - Once the request is sampled low the block drains every DMA buffer headed to PCI.
// RULE_03 - The flush acknowledge goes low only after all those buffers report empty.
// RULE_04 - The flush request arrives synchronous to the PCI clock and is sampled directly.
// RULE_05 - The timer interrupt output follows the internal system timer level at all times; here it lags one clock and is held low during reset.
// RULE_06 - The fixed edge input is always edge triggered and each rising edge is latched.
// RULE_07 - A source on the fixed edge input holds its request until it is acknowledged.
// RULE_08 - If that input drops before acknowledge, the default spurious line's vector answers.
// RULE_09 - The flush acknowledge is driven synchronous to the PCI clock.
// RULE_10 - The acknowledge stays low until the request is released, then rises next edge.
module afh_top
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Flush handshake pins
  input  wire logic       i_buffer_flush_request_n,
  output logic            o_buffer_flush_ack_n,
  // DMA buffer control
  input  wire logic       i_dma_buffers_empty,
  output logic            o_dma_flush,
  // Timer interrupt
  input  wire logic       i_system_timer_irq,
  output logic            o_timer_interrupt_out,
  // Fixed edge interrupt and acknowledge
  input  wire logic       i_fixed_edge_interrupt_in,
  input  wire logic       i_int_ack,
  output logic            o_fixed_edge_pending,
  output logic            o_ack_vector_valid,
  output logic [2:0]      o_ack_vector
);
  afh_pkg::afh_state_t state;
  afh_pkg::afh_state_t next_state;
  logic                pending;
  logic                level_now;

  // Line answered at acknowledge: the source must still be high to count
  function automatic logic [2:0] pick_vector(input logic level);
    if (level)
      pick_vector = afh_pkg::AFH_FIXED_EDGE_LINE; // [RULE_07]
    else
      pick_vector = afh_pkg::AFH_SPURIOUS_LINE; // [RULE_08]
  endfunction : pick_vector

  ////////////////////////////////////////////////////////////////////////
  // Flush sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      afh_pkg::afh_idle_t_s:
        if (!i_buffer_flush_request_n) // [RULE_04]
          next_state = afh_pkg::afh_flush_s; // [RULE_02]
      afh_pkg::afh_flush_s:
        if (i_dma_buffers_empty)
          next_state = afh_pkg::afh_ack_s; // [RULE_03]
      afh_pkg::afh_ack_s:
        if (i_buffer_flush_request_n)
          next_state = afh_pkg::afh_idle_t_s; // [RULE_10]
      default:
        next_state = afh_pkg::afh_idle_t_s;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      state <= afh_pkg::afh_idle_t_s;
    else
      state <= next_state;
  end

  // Drain request held from request sample until buffers report empty
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_dma_flush <= 1'h0;
    else
      o_dma_flush <= (next_state == afh_pkg::afh_flush_s); // [RULE_02]
  end

  // Registered so the APIC can sample it directly on the PCI clock
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_buffer_flush_ack_n <= afh_pkg::AFH_ACK_N_RESET;
    else
      o_buffer_flush_ack_n <= !(next_state == afh_pkg::afh_ack_s); // [RULE_09] [RULE_10]
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer pin
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_timer_interrupt_out <= afh_pkg::AFH_TIMER_OUT_RESET;
    else
      o_timer_interrupt_out <= i_system_timer_irq; // [RULE_05]
  end

  ////////////////////////////////////////////////////////////////////////
  // Fixed edge interrupt
  afh_edge_latch u_edge
  (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_level     (i_fixed_edge_interrupt_in),
    .i_int_ack   (i_int_ack),
    .o_pending   (pending),
    .o_level_now (level_now)
  );

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_fixed_edge_pending <= 1'h0;
    else
      o_fixed_edge_pending <= pending;
  end

  // Source dropped early: answer with the spurious line instead
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_ack_vector_valid <= 1'h0;
      o_ack_vector       <= 3'h0;
    end
    else
    begin
      o_ack_vector_valid <= i_int_ack && pending;
      if (i_int_ack && pending)
        o_ack_vector <= pick_vector(level_now); // [RULE_07] [RULE_08]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks: flush handshake
  a_ack_after_empty: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_03]
    $fell(o_buffer_flush_ack_n) |-> $past(i_dma_buffers_empty))
    else $error("ack before buffers empty");
  a_flush_before_ack: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    $fell(o_buffer_flush_ack_n) |-> $past(o_dma_flush))
    else $error("ack without drain");
  a_req_starts_flush: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    (state == afh_pkg::afh_idle_t_s && !i_buffer_flush_request_n) |=> o_dma_flush)
    else $error("flush not started");
  a_flush_needs_req: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    $rose(o_dma_flush) |-> !$past(i_buffer_flush_request_n))
    else $error("drain without request");
  a_idle_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    (state == afh_pkg::afh_idle_t_s && i_buffer_flush_request_n) |=>
      (o_buffer_flush_ack_n && !o_dma_flush))
    else $error("activity without request");
  // Drain must persist while any buffer still holds PCI-bound data
  a_flush_holds: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
    (o_dma_flush && !i_dma_buffers_empty) |=> o_dma_flush)
    else $error("drain dropped early");
  a_flush_to_ack: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_03]
    (o_dma_flush && i_dma_buffers_empty) |=>
      (!o_dma_flush && !o_buffer_flush_ack_n))
    else $error("ack late after empty");
  a_no_flush_idle: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_03]
    (!o_buffer_flush_ack_n) |-> !o_dma_flush)
    else $error("ack during flush");
  a_ack_not_idle: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_03]
    (state == afh_pkg::afh_idle_t_s) |-> o_buffer_flush_ack_n)
    else $error("ack while idle");

  // Release side of the handshake
  a_ack_release: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
    (!o_buffer_flush_ack_n && i_buffer_flush_request_n) |=> o_buffer_flush_ack_n)
    else $error("ack not released");
  a_ack_holds: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
    (!o_buffer_flush_ack_n && !i_buffer_flush_request_n) |=> !o_buffer_flush_ack_n)
    else $error("ack dropped early");

  ////////////////////////////////////////////////////////////////////////
  // Checks: timer pin
  a_timer_follows: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_05]
    ##1 o_timer_interrupt_out == $past(i_system_timer_irq))
    else $error("timer pin mismatch");

  ////////////////////////////////////////////////////////////////////////
  // Checks: fixed edge interrupt
  // A rising edge in the acknowledge cycle must survive the clear
  a_set_wins: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_06]
    (i_int_ack && i_fixed_edge_interrupt_in && !level_now) |=> pending)
    else $error("edge lost at acknowledge");
  a_pend_needs_edge: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_06]
    $rose(pending) |-> ($past(i_fixed_edge_interrupt_in) && !$past(level_now)))
    else $error("pending without edge");
  a_ack_clears: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_06]
    (i_int_ack && pending && !(i_fixed_edge_interrupt_in && !level_now)) |=> !pending)
    else $error("pending not cleared");
  a_pend_output: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_06]
    1'h1 |=> (o_fixed_edge_pending == $past(pending)))
    else $error("pending pin mismatch");
  // Vector reflects the level one clock before the acknowledge edge
  a_spurious_vec: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_08]
    (i_int_ack && pending && !level_now) |=>
      (o_ack_vector_valid && o_ack_vector == afh_pkg::AFH_SPURIOUS_LINE))
    else $error("spurious vector missing");
  a_real_vec: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_07]
    (i_int_ack && pending && level_now) |=>
      (o_ack_vector_valid && o_ack_vector == afh_pkg::AFH_FIXED_EDGE_LINE))
    else $error("edge vector wrong");
  a_no_vec_idle: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_08]
    !(i_int_ack && pending) |=> !o_ack_vector_valid)
    else $error("vector without pending");
  a_vec_stable: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_08]
    !(i_int_ack && pending) |=> $stable(o_ack_vector))
    else $error("vector changed unasked");
  a_vec_line: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_08]
    o_ack_vector_valid |-> (o_ack_vector == afh_pkg::AFH_FIXED_EDGE_LINE ||
      o_ack_vector == afh_pkg::AFH_SPURIOUS_LINE))
    else $error("vector line illegal");
endmodule : afh_top
`default_nettype wire

/* File: sim/afh_apic_model.sv */
// Behavioural external APIC driving the buffer flush handshake
`timescale 1ns/100ps
`default_nettype none
module afh_apic_model
(
  // Clock and trigger
  input  wire logic i_core_clk,
  input  wire logic i_start,
  // Handshake pins
  input  wire logic i_ack_n,
  output var logic  o_req_n
);
  initial o_req_n = 1'h1;
  // Request only from idle, release once the acknowledge is seen
  always @(posedge i_core_clk)
  begin
    if (i_start && o_req_n)
      o_req_n <= #1 1'h0;
    else if (!i_ack_n)
      o_req_n <= #1 1'h1;
  end
endmodule : afh_apic_model
`default_nettype wire

/* File: sim/tb_afh_top.sv */
// Self-checking bench for the flush handshake and interrupt pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_afh_top;
  logic       clk = 0, rst = 1, empty = 0, tmr = 0, irq = 0, iack = 0, start = 0;
  logic       req_n, ack_n, flush, tout, pend, vval, t_q, e_q, d_q, a_q, q1, q2, r_q;
  logic [2:0] vec, ev;
  logic [2:0] expq[$];
  int         n_errors = 0, check_count = 0, cyc = 0, n_acks = 0, seed = 32'h5ad6;
  initial forever #12.5 clk = ~clk;
  afh_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_buffer_flush_request_n(req_n),
    .o_buffer_flush_ack_n(ack_n), .i_dma_buffers_empty(empty), .o_dma_flush(flush),
    .i_system_timer_irq(tmr), .o_timer_interrupt_out(tout),
    .i_fixed_edge_interrupt_in(irq), .i_int_ack(iack), .o_fixed_edge_pending(pend),
    .o_ack_vector_valid(vval), .o_ack_vector(vec));
  afh_apic_model u_apic (.i_core_clk(clk), .i_start(start), .i_ack_n(ack_n), .o_req_n(req_n));
  //////////////////////////////////////////////////////////////
  // Random timer, buffer state and requests; stalls come from empty
  always @(posedge clk)
  begin
    #1;
    tmr = 1'($random(seed));
    empty = 1'($random(seed));
    start = !rst && 1'($random(seed));
    if (++cyc == 6000)
    begin
      n_errors++;
      finish_test();
    end
  end
  always @(posedge clk)
  begin
    t_q <= tmr;
    e_q <= empty;
    d_q <= flush;
    a_q <= ack_n;
    q1 <= req_n;
    q2 <= q1;
    r_q <= rst;
  end
  always @(negedge clk)
    if (!r_q)
    begin
      `CHK("timer_out", t_q, tout)
      if (a_q && !ack_n)
      begin
        n_acks++;
        `CHK("empty_before_ack", 1'h1, e_q)
        `CHK("flush_before_ack", 1'h1, d_q)
      end
      if (!a_q && ack_n)
      begin
        `CHK("req_released", 1'h1, q1)
        `CHK("ack_rose_next_edge", 1'h0, q2)
      end
      if (vval)
      begin
        ev = expq.size() ? expq.pop_front() : 3'h0;
        `CHK("ack_vector", ev, vec)
      end
    end
  //////////////////////////////////////////////////////////////
  task automatic irq_case(input logic hold);
    irq = 1'h1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("pending", 1'h1, pend)
    // Holding until the acknowledge is the source's duty
    if (!hold)
      irq = 1'h0;
    @(posedge clk);
    #1;
    iack = 1'h1;
    expq.push_back(hold ? afh_pkg::AFH_FIXED_EDGE_LINE : afh_pkg::AFH_SPURIOUS_LINE);
    @(posedge clk);
    #1;
    iack = 1'h0;
    irq = 1'h0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("pending_clear", 1'h0, pend)
  endtask : irq_case
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'h0;
    for (int i = 0; i < 8; i++)
      irq_case(i[0]);
    // Acknowledge with nothing pending must give no vector
    iack = 1'h1;
    @(posedge clk);
    #1;
    iack = 1'h0;
    @(posedge clk);
    #1;
    // Edge in the acknowledge cycle with nothing pending: set must win
    irq = 1'h1;
    iack = 1'h1;
    @(posedge clk);
    #1;
    iack = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("set_wins", 1'h1, pend)
    iack = 1'h1;
    expq.push_back(afh_pkg::AFH_FIXED_EDGE_LINE);
    @(posedge clk);
    #1;
    iack = 1'h0;
    irq = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("set_wins_clear", 1'h0, pend)
    repeat (300) @(posedge clk);
    `CHK("vectors_left", 0, expq.size())
    `CHK("handshakes_done", 1'h1, n_acks > 0)
    finish_test();
  end
endmodule : tb_afh_top
`default_nettype wire
